// ### verilog/tisr_pkg.sv
/*
 Constants for the threshold, interrupt status and modulator timing registers.
 Assumes a byte-wide register port driven by an external serial-bus front end.
*/
// Function
// - Low limit word held as two read/write bytes, upper byte first.
// - High limit word held as two read/write bytes, upper byte first.
// - Status byte reports ready events and limit crossings.
// - Status bits: 3 proximity ready, 2 ambient ready, 1 below low, 0 above high.
// - Flags set by events stay set; writing one clears, zero leaves unchanged.
// - Interrupt pin pulled low while any flag is set.
package tisr_pkg;
   localparam logic [7:0] ADDR_LOW_UPPER  = 8'h8a;
   localparam logic [7:0] ADDR_LOW_LOWER  = 8'h8b;
   localparam logic [7:0] ADDR_HIGH_UPPER = 8'h8c;
   localparam logic [7:0] ADDR_HIGH_LOWER = 8'h8d;
   localparam logic [7:0] ADDR_FLAGS      = 8'h8e;
   localparam logic [7:0] ADDR_MOD_TIMING = 8'h8f;
   localparam logic [7:0] ADDR_AMB_IR     = 8'h90;
   localparam int         BIT_PROX_READY  = 3;
   localparam int         BIT_AMB_READY   = 2;
   localparam int         BIT_BELOW_LOW   = 1;
   localparam int         BIT_ABOVE_HIGH  = 0;
   localparam int         DELAY_MSB       = 7;
   localparam int         DELAY_LSB       = 5;
   localparam int         FREQ_MSB        = 4;
   localparam int         FREQ_LSB        = 3;
   localparam int         DEAD_MSB        = 2;
   localparam int         DEAD_LSB        = 0;
   localparam logic [7:0] RST_LIMIT_BYTE  = 8'h00;
   localparam logic [3:0] RST_FLAGS       = 4'h0;
   localparam logic [7:0] RST_MOD_TIMING  = 8'h01;
endpackage : tisr_pkg

// ### verilog/tisr_regs.sv
/*
 Threshold, interrupt status and modulator timing register block: two 16-bit limit
 words kept as byte pairs, four sticky write-one-to-clear status flags, the open-drain
 interrupt pin enable and the modulator timing byte.
 Assumes reg_wr_i and reg_rd_i are one-cycle strobes from same-clock bus logic, that
 the event and result inputs come from the measurement engine on clock_i, and that
 threshold source selection and enable are decided outside this block.
*/
`timescale 1ns/1ps
`default_nettype none
module tisr_regs (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic        prox_ready_i,
   input  wire logic        amb_ready_i,
   input  wire logic        thresh_en_i,
   input  wire logic        result_valid_i,
   input  wire logic [15:0] result_i,
   output logic      [15:0] low_limit_o,
   output logic      [15:0] high_limit_o,
   output logic      [2:0]  mod_delay_o,
   output logic      [1:0]  prox_freq_o,
   output logic      [2:0]  mod_dead_o,
   output logic             int_o,
   output logic             int_oe_n_o
);

   localparam int NUM_FLAGS = 4;

   // Address selects and the write strobes built from them.
   logic        sel_low_upper_w;
   logic        sel_low_lower_w;
   logic        sel_high_upper_w;
   logic        sel_high_lower_w;
   logic        sel_flags_w;
   logic        sel_mod_w;

   logic        we_low_upper_w;
   logic        we_low_lower_w;
   logic        we_high_upper_w;
   logic        we_high_lower_w;
   logic        we_flags_w;
   logic        we_mod_w;

   // Byte registers, each with the value it takes at the next edge.
   logic [7:0]  low_upper_r;
   logic [7:0]  low_upper_nxt;
   logic [7:0]  low_lower_r;
   logic [7:0]  low_lower_nxt;
   logic [7:0]  high_upper_r;
   logic [7:0]  high_upper_nxt;
   logic [7:0]  high_lower_r;
   logic [7:0]  high_lower_nxt;
   logic [7:0]  mod_r;
   logic [7:0]  mod_nxt;

   logic [15:0] low_w;
   logic [15:0] high_w;
   logic [2:0]  delay_field_w;
   logic [1:0]  freq_field_w;
   logic [2:0]  dead_field_w;

   // Status flags and the events that set them.
   logic [3:0]  flags_r;
   logic [3:0]  flags_nxt;
   logic [3:0]  set_w;
   logic [3:0]  clr_w;
   logic        below_w;
   logic        above_w;
   logic        any_flag_w;

   // Read path: one gated term per mapped byte, ORed together.
   logic [7:0]  rd_low_upper_w;
   logic [7:0]  rd_low_lower_w;
   logic [7:0]  rd_high_upper_w;
   logic [7:0]  rd_high_lower_w;
   logic [7:0]  rd_flags_w;
   logic [7:0]  rd_mod_w;
   logic [7:0]  rdata_sel_w;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;

   assign sel_low_upper_w  = (reg_addr_i == tisr_pkg::ADDR_LOW_UPPER);
   assign sel_low_lower_w  = (reg_addr_i == tisr_pkg::ADDR_LOW_LOWER);
   assign sel_high_upper_w = (reg_addr_i == tisr_pkg::ADDR_HIGH_UPPER);
   assign sel_high_lower_w = (reg_addr_i == tisr_pkg::ADDR_HIGH_LOWER);
   assign sel_flags_w      = (reg_addr_i == tisr_pkg::ADDR_FLAGS);
   assign sel_mod_w        = (reg_addr_i == tisr_pkg::ADDR_MOD_TIMING);

   assign we_low_upper_w  = reg_wr_i & sel_low_upper_w;
   assign we_low_lower_w  = reg_wr_i & sel_low_lower_w;
   assign we_high_upper_w = reg_wr_i & sel_high_upper_w;
   assign we_high_lower_w = reg_wr_i & sel_high_lower_w;
   assign we_flags_w      = reg_wr_i & sel_flags_w;
   assign we_mod_w        = reg_wr_i & sel_mod_w;

   // Each byte is written on its own, so a word read mid-update mixes old and new bytes.
   assign low_upper_nxt  = we_low_upper_w  ? reg_wdata_i : low_upper_r;
   assign low_lower_nxt  = we_low_lower_w  ? reg_wdata_i : low_lower_r;
   assign high_upper_nxt = we_high_upper_w ? reg_wdata_i : high_upper_r;
   assign high_lower_nxt = we_high_lower_w ? reg_wdata_i : high_lower_r;
   assign mod_nxt        = we_mod_w        ? reg_wdata_i : mod_r;

   assign low_w  = {low_upper_r, low_lower_r};
   assign high_w = {high_upper_r, high_lower_r};

   // Comparison is against the assembled words, so a host updating one byte sees a transient limit.
   assign below_w = result_valid_i & thresh_en_i & (result_i < low_w);
   assign above_w = result_valid_i & thresh_en_i & (result_i > high_w);

   assign set_w[tisr_pkg::BIT_PROX_READY] = prox_ready_i;
   assign set_w[tisr_pkg::BIT_AMB_READY]  = amb_ready_i;
   assign set_w[tisr_pkg::BIT_BELOW_LOW]  = below_w;
   assign set_w[tisr_pkg::BIT_ABOVE_HIGH] = above_w;

   // A set in the same cycle as its clear wins, so no event is lost.
   generate
      for (genvar gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
         assign clr_w[gi]      = we_flags_w & reg_wdata_i[gi];
         assign flags_nxt[gi]  = set_w[gi] | (flags_r[gi] & ~clr_w[gi]);
         assign rd_flags_w[gi] = sel_flags_w & flags_r[gi];
      end
   endgenerate
   assign rd_flags_w[7:4] = 4'h0;

   assign rd_low_upper_w  = {8{sel_low_upper_w}}  & low_upper_r;
   assign rd_low_lower_w  = {8{sel_low_lower_w}}  & low_lower_r;
   assign rd_high_upper_w = {8{sel_high_upper_w}} & high_upper_r;
   assign rd_high_lower_w = {8{sel_high_lower_w}} & high_lower_r;
   assign rd_mod_w        = {8{sel_mod_w}}        & mod_r;
   // The reserved ambient IR address and every unmapped address fall through to zero.
   assign rdata_sel_w = rd_low_upper_w
                      | rd_low_lower_w
                      | rd_high_upper_w
                      | rd_high_lower_w
                      | rd_flags_w
                      | rd_mod_w;
   assign rdata_nxt   = reg_rd_i ? rdata_sel_w : rdata_r;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_upper_r <= tisr_pkg::RST_LIMIT_BYTE;
      end else begin
         low_upper_r <= low_upper_nxt;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_lower_r <= tisr_pkg::RST_LIMIT_BYTE;
      end else begin
         low_lower_r <= low_lower_nxt;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         high_upper_r <= tisr_pkg::RST_LIMIT_BYTE;
      end else begin
         high_upper_r <= high_upper_nxt;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         high_lower_r <= tisr_pkg::RST_LIMIT_BYTE;
      end else begin
         high_lower_r <= high_lower_nxt;
      end
   end

   // The reset value is also the setting the host is asked to keep.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mod_r <= tisr_pkg::RST_MOD_TIMING;
      end else begin
         mod_r <= mod_nxt;
      end
   end

   // Flags clear on reset, and the interrupt pin is released with them.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_r <= tisr_pkg::RST_FLAGS;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Read data holds between reads, so a slow serial front end can shift it out at leisure.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Field positions are fixed; the host always writes the whole byte.
   assign delay_field_w = mod_r[tisr_pkg::DELAY_MSB:tisr_pkg::DELAY_LSB];
   assign freq_field_w  = mod_r[tisr_pkg::FREQ_MSB:tisr_pkg::FREQ_LSB];
   assign dead_field_w  = mod_r[tisr_pkg::DEAD_MSB:tisr_pkg::DEAD_LSB];

   assign reg_rdata_o  = rdata_r;
   assign low_limit_o  = low_w;
   assign high_limit_o = high_w;
   assign mod_delay_o  = delay_field_w;
   assign prox_freq_o  = freq_field_w;
   assign mod_dead_o   = dead_field_w;

   assign any_flag_w = |flags_r;
   // Open drain: the pin is only ever pulled low, never driven high.
   assign int_o      = 1'b0;
   assign int_oe_n_o = ~any_flag_w;

endmodule : tisr_regs
`default_nettype wire

// ### tb/tisr_properties.sv
/* Checker for tisr_regs. Assumes a single clock and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module tisr_props (
   input wire logic clock_i, rst_n_i, reg_wr_i, reg_rd_i, prox_ready_i, amb_ready_i, thresh_en_i, result_valid_i,
   input wire logic int_oe_n_o,
   input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire logic [15:0] result_i, low_limit_o, high_limit_o,
   input wire logic [2:0] mod_dead_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence wr_at(a); reg_wr_i && reg_addr_i == a; endsequence
   sequence rd_at(a); reg_rd_i && reg_addr_i == a; endsequence
   a_low_upper_write: assert property (wr_at(8'h8a) |=> low_limit_o[15:8] == $past(reg_wdata_i)) else $error("low");
   a_high_lower_write: assert property (wr_at(8'h8d) |=> high_limit_o[7:0] == $past(reg_wdata_i)) else $error("hi");
   a_prox_sets_pin: assert property (prox_ready_i |=> !int_oe_n_o) else $error("prox");
   a_flag_holds: assert property (!int_oe_n_o && !reg_wr_i |=> !int_oe_n_o) else $error("hold");
   a_below_low_set: assert property (result_valid_i && thresh_en_i && result_i < low_limit_o |=> !int_oe_n_o)
      else $error("below low limit did not set a flag");
   a_above_high_set: assert property (result_valid_i && thresh_en_i && result_i > high_limit_o |=> !int_oe_n_o)
      else $error("above high limit did not set a flag");
   a_set_beats_clear: assert property (wr_at(8'h8e) ##0 (reg_wdata_i[3] && prox_ready_i) |=> !int_oe_n_o)
      else $error("clear overrode a same-cycle set");
   a_limits_gated: assert property (!thresh_en_i && int_oe_n_o && !prox_ready_i && !amb_ready_i |=> int_oe_n_o)
      else $error("gate");
   a_idle_status_read: assert property (rd_at(8'h8e) ##0 int_oe_n_o |=> reg_rdata_o == 8'h00) else $error("st");
   a_status_top_zero: assert property (rd_at(8'h8e) |=> reg_rdata_o[7:4] == 4'h0) else $error("top");
   a_rsvd_reads_zero: assert property (rd_at(8'h90) |=> reg_rdata_o == 8'h00) else $error("rsvd");
   a_dead_default: assert property ($rose(rst_n_i) |-> mod_dead_o == 3'h1) else $error("dead");
endmodule : tisr_props
bind tisr_regs tisr_props u_tisr_props (.*);
`default_nettype wire

// ### tb/tisr_host.sv
/* Host model: one-cycle register strobes. Assumes the bench samples read data after return. */
`timescale 1ns/1ps
`default_nettype none
module tisr_host (input wire logic clock_i, output logic [7:0] addr_o, wdata_o, output logic wr_o, rd_o);
   initial {addr_o, wdata_o, wr_o, rd_o} = '0;
   task automatic xfer(input logic w, input logic [7:0] a, d);
      @(posedge clock_i);
      {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
      @(posedge clock_i);
      // Released address and data lines show the inverse and both strobes drop to zero, so a stale value is never trusted.
      {addr_o, wdata_o, wr_o, rd_o} <= {~a, ~d, 2'b00};
      // Return only once the edge's register updates have settled.
      @(negedge clock_i);
   endtask : xfer
endmodule : tisr_host
`default_nettype wire

// ### tb/tisr_regs_tb.sv
/* Self-checking bench for tisr_regs. Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tisr_regs_tb;
   logic clock_i = 0, rst_n_i = 0, pr = 0, am = 0, en = 0, rv = 0, wr, rd, io, oen;
   logic [7:0] ad, wd, rdat; logic [15:0] res = '0, lo, hi; logic [2:0] dl, dd; logic [1:0] fq;
   int num_errors = 0, checks = 0;
   always #5 clock_i = ~clock_i;
   tisr_host u_tisr_host (.clock_i, .addr_o(ad), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
   tisr_regs u_tisr_regs (.clock_i, .rst_n_i, .reg_addr_i(ad), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
      .reg_rdata_o(rdat), .prox_ready_i(pr), .amb_ready_i(am), .thresh_en_i(en), .result_valid_i(rv),
      .result_i(res), .low_limit_o(lo), .high_limit_o(hi), .mod_delay_o(dl), .prox_freq_o(fq),
      .mod_dead_o(dd), .int_o(io), .int_oe_n_o(oen));
   task automatic chk(input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, e); u_tisr_host.xfer(1'b0, a, 8'h00); chk(rdat, e); endtask : rdc
   task automatic wrr(input logic [7:0] a, d); u_tisr_host.xfer(1'b1, a, d); endtask : wrr
   task automatic pulse(input logic [15:0] r, input logic p, a);
      @(posedge clock_i) {res, rv, pr, am} <= {r, 1'b1, p, a};
      @(posedge clock_i) {rv, pr, am} <= 3'b000;
   endtask : pulse
   task automatic t_mod;
      chk({dl, fq, dd}, 8'h01);
      wrr(8'h8f, 8'he5); chk({dl, fq, dd}, 8'he5);
      wrr(8'h8f, 8'h01); rdc(8'h8f, 8'h01);
      rdc(8'h90, 8'h00); rdc(8'h00, 8'h00);
      $display("t_mod done");
   endtask : t_mod
   task automatic t_limits;
      wrr(8'h8a, 8'h12); wrr(8'h8b, 8'h34); wrr(8'h8c, 8'hfe); wrr(8'h8d, 8'hdc);
      chk(lo, 16'h1234); rdc(8'h8b, 8'h34);
      chk(hi, 16'hfedc); rdc(8'h8c, 8'hfe);
      $display("t_limits done");
   endtask : t_limits
   task automatic t_flags;
      pulse(16'h0000, 1'b1, 1'b1); rdc(8'h8e, 8'h0c); chk(oen, 1'b0); chk(io, 1'b0);
      wrr(8'h8e, 8'hf4); rdc(8'h8e, 8'h08); wrr(8'h8e, 8'h08); chk(oen, 1'b1);
      fork u_tisr_host.xfer(1'b1, 8'h8e, 8'h08); pulse(16'h0000, 1'b1, 1'b0); join
      rdc(8'h8e, 8'h08); wrr(8'h8e, 8'h08); chk(oen, 1'b1);
      @(posedge clock_i) en <= 1'b1;
      pulse(16'hfedc, 1'b0, 1'b0); pulse(16'h1234, 1'b0, 1'b0); rdc(8'h8e, 8'h00);
      pulse(16'h1233, 1'b0, 1'b0); pulse(16'hfedd, 1'b0, 1'b0); rdc(8'h8e, 8'h03);
      wrr(8'h8e, 8'h00); rdc(8'h8e, 8'h03); wrr(8'h8e, 8'h03); chk(oen, 1'b1);
      @(posedge clock_i) en <= 1'b0;
      pulse(16'h0000, 1'b0, 1'b0); rdc(8'h8e, 8'h00);
      $display("t_flags done");
   endtask : t_flags
   task automatic t_reset;
      wrr(8'h8c, 8'h55); pulse(16'h0000, 1'b1, 1'b0);
      @(posedge clock_i) rst_n_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(negedge clock_i);
      chk(hi, 16'h0000); chk(lo, 16'h0000); chk(dd, 3'h1); chk(rdat, 8'h00);
      chk(oen, 1'b1); rdc(8'h8e, 8'h00);
      $display("t_reset done");
   endtask : t_reset
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   initial begin
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_mod(); t_limits(); t_flags(); t_reset(); complete_run();
   end
endmodule : tisr_regs_tb
`default_nettype wire
